// ==== smc_cfg.svh ====
// constants for the standby mode control block
// How it works
// - peripheral idle: cpu stops, subset clocked
// - peripheral idle wakes with run-halt timing
// - peripheral idle: all irqs but watchdog, adc
// - oscillator idle: oscillator on, system clock off
// - oscillator idle: clock output pin held high
// - oscillator idle: async sampling, synchronous resume
// - oscillator idle wakes only on nmi, int zero
// - stop halts everything including the oscillator
// - drive-enable bit selects stop pin behaviour
// - stop wakes only on nmi or int zero
// - leaving stop waits programmed warmup count
// - drive-enable 0 floats invalid pins, 1 drives
// - gated pull-up pins: input gate off in stop when drive-enable is 0
// - halt on port address keeps input gate of invalid pins
// - output-shared pin: pull-up follows function data
// - input-shared pin: port register decides pull-up
// - halt sampling on clock output falling edge
// - maskable request below mask keeps halt
`ifndef SMC_CFG_SVH
`define SMC_CFG_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define SMC_ADDR_W 12
`define SMC_ADDR_CTRL 12'h000
`define SMC_ADDR_HALT 12'h004
`define SMC_ADDR_STAT 12'h008
`define SMC_CTRL_MODE_LSB 0
`define SMC_CTRL_DRVE_BIT 2
`define SMC_CTRL_WARM_LSB 3
`define SMC_CTRL_RST 5'h00
`define SMC_HALT_GO_BIT 0

// ----------------------------------------------------------------
// halt mode codes
// ----------------------------------------------------------------
`define SMC_MODE_RUN 2'h0
`define SMC_MODE_STOP 2'h1
`define SMC_MODE_OIDLE 2'h2
`define SMC_MODE_PIDLE 2'h3

// ----------------------------------------------------------------
// sizes, masks, timing
// ----------------------------------------------------------------
`define SMC_NIRQ 8
`define SMC_NPINS 8
`define SMC_LVL_W 3
`define SMC_NMI_LVL 3'h7
`define SMC_PIDLE_CLK_MASK 8'h0F
`define SMC_ALL_CLK_MASK 8'hFF
`define SMC_INVALID_MASK 8'h0F
`define SMC_GATED_MASK 8'h30
`define SMC_WARM_W 12
`define SMC_WARM_CNT0 12'h0FF
`define SMC_WARM_CNT1 12'h1FF
`define SMC_WARM_CNT2 12'h3FF
`define SMC_WARM_CNT3 12'h7FF

`endif

// ==== smc_ctrl.sv ====
// standby mode controller: halt entry, wake sources, warmup, apb registers
`timescale 1ns/1ps
`include "smc_cfg.svh"
module smc_ctrl (
	// clock, reset and apb register port
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`SMC_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// cpu and interrupt side, same clock
	input wire logic halt_exec,
	input wire logic halt_on_port,
	input wire logic [`SMC_NIRQ-1:0] irq_req,
	input wire logic [`SMC_NIRQ*`SMC_LVL_W-1:0] irq_lvl,
	input wire logic [`SMC_LVL_W-1:0] int_mask,
	input wire logic watchdog_irq,
	input wire logic adc_done_irq,
	// wake pins, asynchronous to pclk
	input wire logic nmi_pin_n,
	input wire logic ext_wake_irq_zero,
	// port settings from the port registers
	input wire smc_pkg::smc_pins_t port_dir,
	input wire smc_pkg::smc_pins_t port_pullup,
	input wire smc_pkg::smc_pins_t fn_out_sel,
	input wire smc_pkg::smc_pins_t fn_out_data,
	// clock and run controls
	output logic cpu_run,
	output logic sys_clk_en,
	output logic [7:0] periph_clk_en,
	output logic osc_en,
	output logic clk_out,
	output logic resume,
	output logic take_irq,
	// pad controls
	output smc_pkg::smc_pins_t pad_oe,
	output smc_pkg::smc_pins_t pad_ie,
	output smc_pkg::smc_pins_t pad_pu
);
	import smc_pkg::*;

	// ----------------------------------------------------------------
	// state and next state
	// ----------------------------------------------------------------
	smc_state_t s_q; // all registered state
	smc_state_t s_d; // next state

	// carrier to the pin block
	smc_pin_if pif ();

	// pin block sees registered stop, drve and port_hold; port settings pass straight in
	assign pif.stop = (s_q.fsm == SMC_HALT_STOP);
	assign pif.drve = s_q.drve;
	assign pif.port_hold = s_q.port_hold;
	assign pif.dir = port_dir;
	assign pif.pu_reg = port_pullup;
	assign pif.fn_out_sel = fn_out_sel;
	assign pif.fn_out_data = fn_out_data;

	smc_pin_ctl u_pins (
		.p(pif.pins)
	);

	// ----------------------------------------------------------------
	// maskable request qualification
	// ----------------------------------------------------------------
	// levels compare unsigned; a mask of zero lets every level in
	logic [`SMC_NIRQ-1:0] irq_ok; // request at or above the mask
	genvar g;
	generate
		for (g = 0; g < `SMC_NIRQ; g++) begin : g_irq
			assign irq_ok[g] = irq_req[g]
				&& (irq_lvl[g*`SMC_LVL_W +: `SMC_LVL_W] >= int_mask);
		end
	endgenerate

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	logic acc; // access phase completes this edge
	logic wr_ctrl; // ctrl register write
	logic wr_halt; // halt command write
	logic hit; // setup address is mapped
	assign acc = psel && penable && s_q.pready;
	assign wr_ctrl = acc && pwrite && (paddr == `SMC_ADDR_CTRL);
	assign wr_halt = acc && pwrite && (paddr == `SMC_ADDR_HALT);
	// hit is judged on the address held through setup and access
	// zero wait state: pready rises in the first access cycle
	assign hit = (paddr == `SMC_ADDR_CTRL) || (paddr == `SMC_ADDR_HALT)
		|| (paddr == `SMC_ADDR_STAT);

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		logic nmi_edge; // falling edge on nmi pin
		logic ext_wake_irq_zero_lvl; // int zero request
		logic wake_any; // wake for run or peripheral idle
		logic wake_ext; // wake from nmi or int zero
		logic fall; // clock output falls this edge
		logic go; // halt instruction executes
		logic ext_wake_irq_zero_only; // int zero below the mask
		nmi_edge = 1'b0;
		ext_wake_irq_zero_lvl = 1'b0;
		wake_any = 1'b0;
		wake_ext = 1'b0;
		fall = 1'b0;
		go = 1'b0;
		ext_wake_irq_zero_only = 1'b0;
		s_d = s_q;

		// pins pass two flip-flops before use
		// nmi_prev adds one more stage for the edge
		s_d.nmi_s1 = !nmi_pin_n;
		s_d.nmi_s2 = s_q.nmi_s1;
		s_d.nmi_prev = s_q.nmi_s2;
		s_d.ext_wake_irq_zero_s1 = ext_wake_irq_zero;
		s_d.ext_wake_irq_zero_s2 = s_q.ext_wake_irq_zero_s1;
		nmi_edge = s_q.nmi_s2 && !s_q.nmi_prev;
		ext_wake_irq_zero_lvl = s_q.ext_wake_irq_zero_s2;

		// the pending flag is not cleared by halt entry, so an edge
		// taken just before a halt releases it at once
		// nmi edge latched; a new edge wins over the clear
		if (s_q.resume) begin
			s_d.nmi_pend = 1'b0;
		end
		if (nmi_edge) begin
			s_d.nmi_pend = 1'b1;
		end

		wake_ext = s_q.nmi_pend || ext_wake_irq_zero_lvl;
		wake_any = wake_ext || (|irq_ok);
		// int zero alone under a nonzero mask releases without
		// interrupt processing; its request stays pending
		ext_wake_irq_zero_only = ext_wake_irq_zero_lvl && !s_q.nmi_pend && !(|irq_ok)
			&& (int_mask != 3'h0);

		// clock output runs at half pclk while the system clock runs
		// a run halt or peripheral idle release is taken only where clk_out is about to fall
		fall = s_q.clk_out;
		s_d.resume = 1'b0;
		s_d.take_irq = s_q.take_irq;

		// apb register slave, zero wait states
		// read data is latched at setup so it stands through access
		s_d.pready = psel && !penable;
		s_d.pslverr = psel && !penable && !hit;
		s_d.prdata = 32'h0000_0000;
		if (psel && !penable && !pwrite) begin
			case (paddr)
				`SMC_ADDR_CTRL: begin
					s_d.prdata[4:0] = {s_q.warm, s_q.drve, s_q.mode};
				end
				`SMC_ADDR_STAT: begin
					s_d.prdata[2:0] = s_q.fsm;
					s_d.prdata[3] = s_q.take_irq;
					s_d.prdata[4] = s_q.port_hold;
					s_d.prdata[5] = s_q.nmi_pend;
					s_d.prdata[6] = ext_wake_irq_zero_lvl;
				end
				default: begin
					s_d.prdata = 32'h0000_0000;
				end
			endcase
		end
		// bits above the warmup field are ignored
		if (wr_ctrl) begin
			s_d.mode = pwdata[`SMC_CTRL_MODE_LSB +: 2];
			s_d.drve = pwdata[`SMC_CTRL_DRVE_BIT];
			s_d.warm = pwdata[`SMC_CTRL_WARM_LSB +: 2];
		end
		// a halt write and the halt instruction are treated alike
		go = halt_exec || (wr_halt && pwdata[`SMC_HALT_GO_BIT]);

		case (s_q.fsm)
			SMC_RUN: begin
				s_d.clk_out = !s_q.clk_out;
				if (go) begin
					// enter the preselected mode
					// port_hold decides whether invalid pins keep their gate
					s_d.port_hold = halt_on_port;
					// the cpu stops on the same edge that takes the halt
					s_d.cpu_run = 1'b0;
					// mode encodings follow the control register field
					case (s_q.mode)
						`SMC_MODE_PIDLE: begin
							// only a subset keeps its clock
							// upper peripherals lose their clock until release
							s_d.fsm = SMC_HALT_PIDLE;
							s_d.periph_clk_en = `SMC_PIDLE_CLK_MASK;
						end
						`SMC_MODE_OIDLE: begin
							s_d.fsm = SMC_HALT_OIDLE;
							s_d.sys_clk_en = 1'b0;
							s_d.periph_clk_en = 8'h00;
							s_d.clk_out = 1'b1;
						end
						`SMC_MODE_STOP: begin
							s_d.fsm = SMC_HALT_STOP;
							s_d.sys_clk_en = 1'b0;
							s_d.periph_clk_en = 8'h00;
							s_d.osc_en = 1'b0;
							s_d.clk_out = 1'b1;
						end
						default: begin
							s_d.fsm = SMC_HALT_RUN;
						end
					endcase
				end
			end
			SMC_HALT_RUN,
			SMC_HALT_PIDLE: begin
				s_d.clk_out = !s_q.clk_out;
				// same release timing as run halt
				if (fall && wake_any) begin
					s_d.fsm = SMC_RUN;
					s_d.cpu_run = 1'b1;
					s_d.periph_clk_en = `SMC_ALL_CLK_MASK;
					s_d.resume = 1'b1;
					s_d.take_irq = !ext_wake_irq_zero_only;
					s_d.port_hold = 1'b0;
				end else if (s_q.fsm == SMC_HALT_RUN && fall && watchdog_irq
					&& !wake_ext) begin
					// watchdog may still end a run-mode halt
					s_d.fsm = SMC_RUN;
					s_d.cpu_run = 1'b1;
					s_d.resume = 1'b1;
					s_d.take_irq = 1'b1;
					s_d.port_hold = 1'b0;
				end else if (s_q.fsm == SMC_HALT_RUN && fall && adc_done_irq) begin
					// adc completion also ends only the run-mode halt
					s_d.fsm = SMC_RUN;
					s_d.cpu_run = 1'b1;
					s_d.resume = 1'b1;
					s_d.take_irq = 1'b1;
					s_d.port_hold = 1'b0;
				end
			end
			SMC_HALT_OIDLE: begin
				s_d.clk_out = 1'b1;
				// pin seen asynchronously, resume on pclk
				// only nmi or int zero release
				// peripherals are unclocked, so maskable requests are ignored
				if (wake_ext) begin
					s_d.fsm = SMC_RUN;
					s_d.cpu_run = 1'b1;
					s_d.sys_clk_en = 1'b1;
					s_d.periph_clk_en = `SMC_ALL_CLK_MASK;
					s_d.resume = 1'b1;
					s_d.take_irq = !ext_wake_irq_zero_only;
					s_d.port_hold = 1'b0;
				end
			end
			SMC_HALT_STOP: begin
				s_d.clk_out = 1'b1;
				// only nmi or int zero release
				if (wake_ext) begin
					// restart oscillator, count warmup
					// the system clock stays off until the count ends
					s_d.fsm = SMC_WARMUP;
					s_d.osc_en = 1'b1;
					s_d.take_irq = !ext_wake_irq_zero_only;
					case (s_q.warm)
						2'h0: s_d.warm_cnt = `SMC_WARM_CNT0;
						2'h1: s_d.warm_cnt = `SMC_WARM_CNT1;
						2'h2: s_d.warm_cnt = `SMC_WARM_CNT2;
						default: s_d.warm_cnt = `SMC_WARM_CNT3;
					endcase
				end
			end
			SMC_WARMUP: begin
				// clock withheld until count ends
				// the loaded value is counted down to zero: N+1 cycles
				s_d.clk_out = 1'b1;
				if (s_q.warm_cnt == '0) begin
					s_d.fsm = SMC_RUN;
					s_d.cpu_run = 1'b1;
					s_d.sys_clk_en = 1'b1;
					s_d.periph_clk_en = `SMC_ALL_CLK_MASK;
					s_d.resume = 1'b1;
					s_d.port_hold = 1'b0;
				end else begin
					s_d.warm_cnt = s_q.warm_cnt - 1'b1;
				end
			end
			default: begin
				// unused encodings fall back to run
				s_d.fsm = SMC_RUN;
			end
		endcase

		// pad controls registered from the pin block
		// one cycle late, so stop pad states lag the state by a cycle
		s_d.pad_oe = pif.oe;
		s_d.pad_ie = pif.ie;
		s_d.pad_pu = pif.pu;
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	// reset brings the part up running with every clock on
	// and every input gate open
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.fsm <= SMC_RUN;
			s_q.cpu_run <= 1'b1;
			s_q.sys_clk_en <= 1'b1;
			s_q.periph_clk_en <= `SMC_ALL_CLK_MASK;
			s_q.osc_en <= 1'b1;
			s_q.pad_ie <= '1;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs straight from flops
	// ----------------------------------------------------------------
	// nothing combinational reaches a pin of this block
	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign cpu_run = s_q.cpu_run;
	assign sys_clk_en = s_q.sys_clk_en;
	assign periph_clk_en = s_q.periph_clk_en;
	assign osc_en = s_q.osc_en;
	assign clk_out = s_q.clk_out;
	assign resume = s_q.resume;
	assign take_irq = s_q.take_irq;
	assign pad_oe = s_q.pad_oe;
	assign pad_ie = s_q.pad_ie;
	assign pad_pu = s_q.pad_pu;
endmodule // smc_ctrl

// ==== smc_ctrl_monitor.sv ====
// port checker for the standby mode controller
`timescale 1ns/1ps
`include "smc_cfg.svh"
module smc_ctrl_monitor (
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [`SMC_ADDR_W-1:0] paddr,
	input logic [31:0] pwdata,
	input logic pready,
	input logic pslverr,
	input logic cpu_run,
	input logic sys_clk_en,
	input logic [7:0] periph_clk_en,
	input logic osc_en,
	input logic clk_out,
	input logic resume,
	input logic nmi_pin_n,
	input logic ext_wake_irq_zero,
	input smc_pkg::smc_pins_t pad_oe,
	input smc_pkg::smc_pins_t pad_ie
);
	import smc_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic drve_q; // shadow of the drive-enable bit
	// ------
	// shadow control writes
	// ------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drve_q <= 1'b0;
		end else if (psel && penable && pready && pwrite && paddr == `SMC_ADDR_CTRL) begin
			drve_q <= pwdata[`SMC_CTRL_DRVE_BIT];
		end
	end
	a_apb_zero_wait: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_err_in_access: assert property (pslverr |-> pready && psel && penable)
		else $error("error outside access");
	a_clk_held_high: assert property (!sys_clk_en |-> clk_out)
		else $error("clock output not high");
	a_clk_toggles: assert property (sys_clk_en && $past(sys_clk_en) && $past(presetn)
		|-> clk_out != $past(clk_out))
		else $error("clock output stuck");
	a_stop_all_off: assert property (!osc_en |-> !sys_clk_en && !cpu_run && periph_clk_en == 8'h00)
		else $error("clock alive in stop");
	a_run_clocks: assert property (cpu_run |-> sys_clk_en && osc_en && periph_clk_en == 8'hFF)
		else $error("clock off while running");
	a_resume_once: assert property ($rose(cpu_run) |-> resume ##1 !resume)
		else $error("resume pulse wrong");
	a_stop_no_wake: assert property ((!osc_en && !ext_wake_irq_zero && nmi_pin_n)[*6] |=> !osc_en)
		else $error("stop left without wake");
	a_float_pins: assert property (!osc_en && !$past(osc_en) && !drve_q |-> (pad_oe & 8'h0F) == 8'h00)
		else $error("invalid pin driven");
	a_gate_off: assert property (!osc_en && !$past(osc_en) && !drve_q |-> (pad_ie & 8'h30) == 8'h00)
		else $error("gated input on");
endmodule // smc_ctrl_monitor
bind smc_ctrl smc_ctrl_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .cpu_run(cpu_run), .sys_clk_en(sys_clk_en),
	.periph_clk_en(periph_clk_en), .osc_en(osc_en), .clk_out(clk_out), .resume(resume),
	.nmi_pin_n(nmi_pin_n), .ext_wake_irq_zero(ext_wake_irq_zero), .pad_oe(pad_oe),
	.pad_ie(pad_ie));

// ==== smc_pin_ctl.sv ====
// per-pin drive, input gate and pull-up selection in and out of stop
`timescale 1ns/1ps
`include "smc_cfg.svh"
module smc_pin_ctl (
	smc_pin_if.pins p
);
	import smc_pkg::*;

	// ----------------------------------------------------------------
	// one slice per pin
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < `SMC_NPINS; i++) begin : g_pin
			localparam smc_pins_t INV = `SMC_INVALID_MASK;
			localparam smc_pins_t GAT = `SMC_GATED_MASK;
			logic float_it; // pin released in stop
			always_comb begin
				// invalid pins float when drive off
				float_it = p.stop && !p.drve && INV[i];
				p.oe[i] = p.dir[i] && !float_it;
				if (float_it) begin
					p.ie[i] = p.port_hold;
				end else if (p.stop && !p.drve && GAT[i]) begin
					p.ie[i] = 1'b0;
				end else begin
					p.ie[i] = 1'b1;
				end
				if (p.fn_out_sel[i]) begin
					p.pu[i] = p.fn_out_data[i];
				end else begin
					p.pu[i] = p.pu_reg[i];
				end
				// no pull-up fighting a driven pin that carries no output function
				if (p.oe[i] && !p.fn_out_sel[i]) begin
					p.pu[i] = 1'b0;
				end
			end
		end
	endgenerate
endmodule // smc_pin_ctl

// ==== smc_pin_if.sv ====
// carrier between the controller and the pin stop-state logic
`timescale 1ns/1ps
interface smc_pin_if;
	import smc_pkg::*;
	logic stop; // stop mode is active
	logic drve; // drive-enable bit
	logic port_hold; // halted while addressing a port register
	smc_pins_t dir; // 1 = output mode
	smc_pins_t pu_reg; // port register pull-up bits
	smc_pins_t fn_out_sel; // pin carries an output function
	smc_pins_t fn_out_data; // output function data
	smc_pins_t oe; // computed output enable
	smc_pins_t ie; // computed input gate enable
	smc_pins_t pu; // computed pull-up enable
	modport ctl (output stop, drve, port_hold, dir, pu_reg, fn_out_sel, fn_out_data,
		input oe, ie, pu);
	modport pins (input stop, drve, port_hold, dir, pu_reg, fn_out_sel, fn_out_data,
		output oe, ie, pu);
endinterface // smc_pin_if

// ==== smc_pkg.sv ====
// types shared by the standby mode control block
`include "smc_cfg.svh"
package smc_pkg;
	// controller states
	typedef enum logic [2:0] {
		SMC_RUN,
		SMC_HALT_RUN,
		SMC_HALT_PIDLE,
		SMC_HALT_OIDLE,
		SMC_HALT_STOP,
		SMC_WARMUP
	} smc_fsm_t;

	typedef logic [`SMC_NPINS-1:0] smc_pins_t;

	// whole state of the top module
	typedef struct packed {
		smc_fsm_t fsm;
		logic [1:0] mode;
		logic drve;
		logic [1:0] warm;
		logic nmi_s1;
		logic nmi_s2;
		logic nmi_prev;
		logic nmi_pend;
		logic ext_wake_irq_zero_s1;
		logic ext_wake_irq_zero_s2;
		logic clk_out;
		logic [`SMC_WARM_W-1:0] warm_cnt;
		logic port_hold;
		logic cpu_run;
		logic sys_clk_en;
		logic [7:0] periph_clk_en;
		logic osc_en;
		logic resume;
		logic take_irq;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		smc_pins_t pad_oe;
		smc_pins_t pad_ie;
		smc_pins_t pad_pu;
	} smc_state_t;
endpackage

// ==== smc_wake_src.sv ====
// far-side model of the wake pins, run from the oscillator domain
`timescale 1ns/1ps
module smc_wake_src (
	output logic nmi_pin_n,
	output logic ext_wake_irq_zero
);
	logic oclk = 1'b0; // unrelated in phase to pclk
	always #18.5 oclk = ~oclk;
	initial begin
		nmi_pin_n = 1'b1;
		ext_wake_irq_zero = 1'b0;
	end
	// short low pulse: the falling edge is what counts
	task automatic nmi_pulse();
		@(posedge oclk) nmi_pin_n <= 1'b0;
		repeat (4) @(posedge oclk);
		nmi_pin_n <= 1'b1;
	endtask
	// level wake, held until dropped
	task automatic ext_wake_irq_zero_set(input logic v);
		@(posedge oclk) ext_wake_irq_zero <= v;
	endtask
endmodule // smc_wake_src

// ==== test_standby_mode_control.sv ====
// self-checking bench for the standby mode controller
`timescale 1ns/1ps
`include "smc_cfg.svh"
module test_standby_mode_control;
	import smc_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h0000000E;
	logic pready, pslverr, err, halt_exec = 1'b0, halt_on_port = 1'b0;
	logic [7:0] irq_req = 8'h00, periph_clk_en;
	logic [23:0] irq_lvl = 24'h0;
	logic [2:0] int_mask = 3'h0;
	logic watchdog_irq = 1'b0, adc_done_irq = 1'b0, nmi_pin_n, ext_wake_irq_zero;
	smc_pins_t port_dir = 8'h00, port_pullup = 8'h00, fn_out_sel = 8'h00, fn_out_data = 8'h00;
	smc_pins_t pad_oe, pad_ie, pad_pu;
	logic cpu_run, sys_clk_en, osc_en, clk_out, resume, take_irq;
	int bad_count = 0, cmp_count = 0, cyc = 0;
	always #20 pclk = ~pclk;
	smc_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .halt_exec(halt_exec), .halt_on_port(halt_on_port),
		.irq_req(irq_req), .irq_lvl(irq_lvl), .int_mask(int_mask), .watchdog_irq(watchdog_irq),
		.adc_done_irq(adc_done_irq), .nmi_pin_n(nmi_pin_n), .ext_wake_irq_zero(ext_wake_irq_zero),
		.port_dir(port_dir), .port_pullup(port_pullup), .fn_out_sel(fn_out_sel),
		.fn_out_data(fn_out_data), .cpu_run(cpu_run), .sys_clk_en(sys_clk_en),
		.periph_clk_en(periph_clk_en), .osc_en(osc_en), .clk_out(clk_out), .resume(resume),
		.take_irq(take_irq), .pad_oe(pad_oe), .pad_ie(pad_ie), .pad_pu(pad_pu));
	smc_wake_src wk (.nmi_pin_n(nmi_pin_n), .ext_wake_irq_zero(ext_wake_irq_zero));
	// ------
	// helpers
	// ------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// pull-up follows function data on function pins, else the port bit
	function automatic smc_pins_t exp_pu(smc_pins_t sel, smc_pins_t dat, smc_pins_t pr);
		return (sel & dat) | (~sel & pr);
	endfunction
	// warmup length, select count plus one
	function automatic int warm_n(int sel);
		return 256 << sel;
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// hang guard, well above the longest warmup sweep
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	// one apb transfer, entered just after an edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// no limit here: the hang guard ends a stuck wait
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic halt(input logic [1:0] m, input logic dv, input logic [1:0] w, input logic r);
		apb(1'b1, `SMC_ADDR_CTRL, {27'h0, w, dv, m});
		if (r) begin
			apb(1'b1, `SMC_ADDR_HALT, 32'h1);
		end else begin
			halt_exec <= 1'b1;
			@(posedge pclk);
			halt_exec <= 1'b0;
		end
		repeat (3) @(posedge pclk);
	endtask
	task automatic wait_run(output int n);
		n = 0;
		while (cpu_run !== 1'b1 && n < 4000) begin
			@(posedge pclk);
			n++;
		end
		chk("resumed", cpu_run, 32'h1);
	endtask
	// ------
	// main sequence
	// ------
	initial begin
		int n;
		logic [31:0] v;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, `SMC_ADDR_CTRL, 32'h0);
		chk("ctrl_rst", rd, 32'h0);
		v = rnd();
		apb(1'b1, `SMC_ADDR_CTRL, v);
		apb(1'b0, `SMC_ADDR_CTRL, 32'h0);
		chk("ctrl_rw", rd, {27'h0, v[4:0]});
		apb(1'b1, 12'h00C, v);
		chk("unmapped_err", err, 32'h1);
		apb(1'b0, `SMC_ADDR_STAT, 32'h0);
		chk("stat_run", rd[2:0], 32'h0);
		for (int i = 0; i < 8; i++) begin
			v = rnd();
			{port_pullup, fn_out_data, fn_out_sel, port_dir} <= v;
			repeat (2) @(posedge pclk);
			@(negedge pclk);
			chk("pullup", pad_pu & ~port_dir, exp_pu(fn_out_sel, fn_out_data, port_pullup) & ~port_dir);
			@(posedge pclk);
		end
		int_mask <= 3'h5;
		irq_lvl <= {8{3'h2}};
		irq_req <= 8'h04;
		halt(`SMC_MODE_RUN, 1'b0, 2'h0, 1'b0);
		repeat (20) @(posedge pclk);
		chk("below_mask", cpu_run, 32'h0);
		irq_lvl <= {8{3'h6}};
		wait_run(n);
		chk("run_take", take_irq, 32'h1);
		irq_req <= 8'h00;
		halt(`SMC_MODE_RUN, 1'b0, 2'h0, 1'b0);
		watchdog_irq <= 1'b1;
		wait_run(n);
		chk("run_wdog", cpu_run, 32'h1);
		watchdog_irq <= 1'b0;
		halt(`SMC_MODE_RUN, 1'b0, 2'h0, 1'b0);
		adc_done_irq <= 1'b1;
		wait_run(n);
		chk("run_adc", cpu_run, 32'h1);
		adc_done_irq <= 1'b0;
		watchdog_irq <= 1'b0;
		halt(`SMC_MODE_PIDLE, 1'b0, 2'h0, 1'b1);
		@(negedge pclk);
		chk("pidle_clk", {cpu_run, sys_clk_en, periph_clk_en}, {2'b01, 8'h0F});
		@(posedge pclk);
		watchdog_irq <= 1'b1;
		adc_done_irq <= 1'b1;
		repeat (20) @(posedge pclk);
		chk("pidle_hold", cpu_run, 32'h0);
		watchdog_irq <= 1'b0;
		adc_done_irq <= 1'b0;
		irq_req <= 8'h01 << v[2:0];
		wait_run(n);
		chk("pidle_lat", n <= 4, 32'h1);
		irq_req <= 8'hFF;
		halt(`SMC_MODE_OIDLE, 1'b0, 2'h0, 1'b0);
		@(negedge pclk);
		chk("oidle", {cpu_run, sys_clk_en, osc_en, clk_out}, 32'h3);
		repeat (20) @(posedge pclk);
		chk("oidle_hold", cpu_run, 32'h0);
		wk.nmi_pulse();
		wait_run(n);
		chk("oidle_nmi", take_irq, 32'h1);
		for (int i = 0; i < 4; i++) begin
			v = rnd();
			halt_on_port <= v[1];
			int_mask <= v[4:2];
			irq_req <= 8'hFF;
			watchdog_irq <= 1'b1;
			halt(`SMC_MODE_STOP, v[0], i[1:0], v[5]);
			@(negedge pclk);
			chk("stop_osc", osc_en, 32'h0);
			chk("stop_oe", pad_oe & 8'h0F, v[0] ? port_dir & 8'h0F : 8'h00);
			if (!v[0]) chk("stop_ie", pad_ie & 8'h3F, {4'h0, {4{v[1]}}});
			repeat (9) @(posedge pclk);
			chk("stop_hold", osc_en, 32'h0);
			irq_req <= 8'h00;
			watchdog_irq <= 1'b0;
			if (v[6]) fork wk.nmi_pulse(); join_none
			else wk.ext_wake_irq_zero_set(1'b1);
			n = 0;
			while (osc_en !== 1'b1 && n < 100) begin
				@(posedge pclk);
				n++;
			end
			wait_run(n);
			chk("warm_len", n >= warm_n(i) - 1 && n <= warm_n(i) + 1, 32'h1);
			chk("stop_take", take_irq, v[6] | (v[4:2] == 3'h0));
			wk.ext_wake_irq_zero_set(1'b0);
			@(posedge pclk);
		end
		tally_and_finish();
	end
endmodule // test_standby_mode_control
